// ==== include/mpt_pkg.sv ====
// Shared constants, register map and carrier types of the multichannel PWM timer
package mpt_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NCH = 8; // Number of 8-bit channels
	localparam int NPAIR = 4; // Adjacent channel pairs
	localparam int BW = 8; // Width of one channel setting
	localparam int CH_W = 16; // Engine width, wide enough for a joined pair

	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [7:0] OFS_ENABLE = 8'h00; // Channel enables
	localparam logic [7:0] OFS_POLARITY = 8'h04; // 1 = active high
	localparam logic [7:0] OFS_CENTER = 8'h08; // 1 = center aligned
	localparam logic [7:0] OFS_PCM = 8'h0c; // 1 = PCM (pulse density) output
	localparam logic [7:0] OFS_CONCAT = 8'h10; // Pair joins, bit p joins 2p+1:2p
	localparam logic [7:0] OFS_OUTSTAT = 8'h14; // Read only, pin levels
	localparam logic [7:0] OFS_PERIOD = 8'h20; // Bank, one word per channel
	localparam logic [7:0] OFS_DUTY = 8'h40; // Bank, one word per channel
	localparam logic [7:0] OFS_COUNT = 8'h60; // Bank, read only counters
	localparam int BANK_LSB = 5; // Bank select field
	localparam int IDX_LSB = 2; // Word index inside a bank
	localparam logic [2:0] BANK_CTRL = 3'h0; // Bank of the control words
	localparam logic [2:0] IDX_LAST_RW = 3'h4; // Last writable control word
	localparam logic [2:0] IDX_OUTSTAT = 3'h5; // Status word index

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_BYTE = 8'h00; // Default of most fields
	localparam logic [7:0] RST_POLARITY = 8'hff; // All outputs active high
	localparam logic [7:0] RST_PERIOD = 8'hff; // Full 8-bit period

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic center; // Up/down counting
		logic pcm; // Pulse density output
		logic [CH_W-1:0] per; // Period
		logic [CH_W-1:0] duty; // Active length
	} mpt_chcfg_t;

	typedef struct packed {
		logic [7:0] addr; // Byte address
		logic wr; // Write when set
		logic [31:0] wdata; // Write data
		logic [3:0] strb; // Byte lanes
	} mpt_apbreq_t;

endpackage

// ==== rtl/mpt_pcm.sv ====
// Pulse density (PCM) generator of one channel
`timescale 1ns/1ns
`default_nettype none

module mpt_pcm #(
	parameter int W = mpt_pkg::CH_W
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic en, // Runs while set
	input wire logic [W-1:0] per, // Denominator
	input wire logic [W-1:0] duty, // Numerator
	output logic pulse // Active slot
);

	// ****************************************
	// Accumulator
	// ****************************************
	if (W < 2 || W > mpt_pkg::CH_W)
	begin : g_bad_w
		$error("mpt_pcm: unsupported width");
	end

	logic [W-1:0] acc; // Remainder, below per except when per is zero or has just been lowered
	logic [W-1:0] next_acc;
	logic next_pulse;
	logic [W:0] sum; // One bit wider so the add never wraps
	logic full; // 100 percent setting

	// Spreads duty/per active slots evenly, which pushes ripple to high frequency
	always_comb
	begin
		sum = {1'b0, acc} + {1'b0, duty};
		full = (duty >= per) && (duty != '0);
		next_acc = acc;
		next_pulse = 1'b0;
		if (!en)
			next_acc = '0;
		else if (full)
		begin
			next_pulse = 1'b1;
			next_acc = '0;
		end
		else if (per != '0 && sum >= {1'b0, per})
		begin
			next_pulse = 1'b1;
			next_acc = W'(sum - {1'b0, per});
		end
		else
			next_acc = (per == '0) ? '0 : sum[W-1:0];
	end

	// State registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			acc <= '0;
			pulse <= 1'b0;
		end
		else
		begin
			acc <= next_acc;
			pulse <= next_pulse;
		end
	end

	AST_PCM_ZERO: assert property (@(posedge clk) disable iff (rst)
		(duty == '0) |=> !pulse) else $error("pcm pulse with zero duty");
	AST_PCM_FULL: assert property (@(posedge clk) disable iff (rst)
		(en && duty >= per && duty != '0) |=> pulse) else $error("pcm not full");

endmodule
`default_nettype wire

// ==== rtl/mpt_chan.sv ====
// Counter and compare engine of one channel, with boundary-loaded shadow settings
`timescale 1ns/1ns
`default_nettype none

module mpt_chan #(
	parameter int W = mpt_pkg::CH_W
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic en, // Channel runs while set
	input wire mpt_pkg::mpt_chcfg_t cfg, // Settings as software wrote them
	output mpt_pkg::mpt_chcfg_t sh, // Settings in force
	output logic [W-1:0] cnt, // Counter
	output logic active // Compare result
);

	// ****************************************
	// Counter
	// ****************************************
	if (W != mpt_pkg::CH_W)
	begin : g_bad_w
		$error("mpt_chan: width must match the settings");
	end

	logic down; // Counting down in center mode
	logic bnd; // Last count of the period
	logic full; // 100 percent setting
	logic next_down;
	logic next_active;
	logic [W-1:0] next_cnt;
	mpt_pkg::mpt_chcfg_t next_sh;

	// End of period: left wraps at per-1, center turns back at zero
	assign bnd = sh.center ? (sh.per == '0 || (down && cnt == '0))
		: (sh.per == '0 || cnt >= sh.per - 1'b1);

	// Next count, direction and shadow
	always_comb
	begin
		full = (sh.duty >= sh.per) && (sh.duty != '0);
		next_cnt = cnt;
		next_down = down;
		next_sh = sh;
		next_active = 1'b0;
		if (!en)
		begin
			// Idle channel takes new settings at once
			next_cnt = '0;
			next_down = 1'b0;
			next_sh = cfg;
		end
		else
		begin
			next_active = full || (cnt < sh.duty);
			if (bnd)
				next_sh = cfg;
			if (!sh.center)
				next_cnt = bnd ? '0 : cnt + 1'b1;
			else if (sh.per == '0)
			begin
				next_cnt = '0;
				next_down = 1'b0;
			end
			else if (!down)
			begin
				if (cnt >= sh.per)
				begin
					next_down = 1'b1;
					next_cnt = cnt - 1'b1;
				end
				else
					next_cnt = cnt + 1'b1;
			end
			else if (cnt == '0)
			begin
				next_down = 1'b0;
				next_cnt = cnt + 1'b1;
			end
			else
				next_cnt = cnt - 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt <= '0;
			down <= 1'b0;
			sh <= '0;
			active <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			down <= next_down;
			sh <= next_sh;
			active <= next_active;
		end
	end

	sequence s_top;
		en && sh.center && !down && sh.per != '0 && cnt >= sh.per;
	endsequence
	AST_CENTER_TURN: assert property (@(posedge clk) disable iff (rst)
		s_top |=> down ##0 cnt == $past(cnt) - 1'b1) else $error("no turn at top");
	AST_LEFT_WRAP: assert property (@(posedge clk) disable iff (rst)
		(en && !sh.center && bnd) |=> cnt == '0) else $error("left no wrap");
	AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst)
		(en && !sh.center && !bnd) |=> cnt == $past(cnt) + 1'b1) else $error("bad step");
	AST_ZERO_DUTY: assert property (@(posedge clk) disable iff (rst)
		(sh.duty == '0) |=> !active) else $error("active at zero duty");
	AST_FULL_DUTY: assert property (@(posedge clk) disable iff (rst)
		(en && full) |=> active) else $error("not full at full duty");
	AST_SHADOW_HOLD: assert property (@(posedge clk) disable iff (rst)
		(en && !bnd) |=> sh == $past(sh)) else $error("setting changed mid period");
	AST_IDLE: assert property (@(posedge clk) disable iff (rst)
		!en |=> (cnt == '0 && !active)) else $error("idle channel running");

endmodule
`default_nettype wire

// ==== rtl/mpt_top.sv ====
// Eight-channel PWM timer with APB register access
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Eight 8-bit channels, own counter, period, duty
// - Duty ranges from always off to always on
// - PCM pulse density mode per channel
// - Per-channel output polarity select
// - Left (wrap) or center (up/down) alignment
// - Adjacent pairs join into 16-bit channels
module mpt_top (
	input wire logic CLK_SYS, // System clock
	input wire logic SYS_RST, // Synchronous reset, active high
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB direction
	input wire logic [7:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	input wire logic [3:0] PSTRB, // APB byte lanes
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error
	output logic [7:0] PWM_OUT // Waveform pins
);

	// ****************************************
	// Register decode
	// ****************************************

	// True when the word exists and allows the access
	function automatic logic reg_ok(input logic [7:0] a, input logic wr);
		logic [2:0] bank;
		logic [2:0] idx;
		bank = a[mpt_pkg::BANK_LSB+:3];
		idx = a[mpt_pkg::IDX_LSB+:3];
		reg_ok = 1'b0;
		if (a[1:0] == 2'h0)
		begin
			if (bank == mpt_pkg::BANK_CTRL)
				reg_ok = wr ? (idx <= mpt_pkg::IDX_LAST_RW)
					: (idx <= mpt_pkg::IDX_OUTSTAT);
			else if (bank == mpt_pkg::OFS_PERIOD[mpt_pkg::BANK_LSB+:3])
				reg_ok = 1'b1;
			else if (bank == mpt_pkg::OFS_DUTY[mpt_pkg::BANK_LSB+:3])
				reg_ok = 1'b1;
			else if (bank == mpt_pkg::OFS_COUNT[mpt_pkg::BANK_LSB+:3])
				reg_ok = !wr; // Counters are read only
		end
	endfunction

	// ****************************************
	// Registers and wires
	// ****************************************
	logic [7:0] en_r; // Channel enables
	logic [7:0] pol_r; // Polarity, 1 = active high
	logic [7:0] cen_r; // Center alignment
	logic [7:0] pcm_r; // PCM mode
	logic [3:0] cat_r; // Pair joins
	logic [7:0] per_r [mpt_pkg::NCH]; // Period settings
	logic [7:0] duty_r [mpt_pkg::NCH]; // Duty settings
	logic [7:0] next_en;
	logic [7:0] next_pol;
	logic [7:0] next_cen;
	logic [7:0] next_pcm;
	logic [3:0] next_cat;
	logic [7:0] next_per [mpt_pkg::NCH];
	logic [7:0] next_duty [mpt_pkg::NCH];
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [7:0] next_pwm;
	mpt_pkg::mpt_apbreq_t req; // Request bundle
	logic wr_go; // Write takes effect this edge
	logic [2:0] bank; // Bank of the request
	logic [2:0] idx; // Word of the request

	mpt_pkg::mpt_chcfg_t cfg [mpt_pkg::NCH]; // Settings into each engine
	mpt_pkg::mpt_chcfg_t sh [mpt_pkg::NCH]; // Settings in force
	logic [mpt_pkg::CH_W-1:0] cnt [mpt_pkg::NCH]; // Engine counters
	logic [7:0] cnt_view; // Counter bytes as software sees them
	logic [7:0] ch_en; // Engine runs
	logic [7:0] act; // Compare results
	logic [7:0] pulse; // PCM results
	logic [7:0] pick; // Result of the chosen mode
	logic [7:0] mute; // Low half of a joined pair

	assign req = '{addr: PADDR, wr: PWRITE, wdata: PWDATA, strb: PSTRB};
	assign bank = req.addr[mpt_pkg::BANK_LSB+:3];
	assign idx = req.addr[mpt_pkg::IDX_LSB+:3];
	// Only the low lane carries data; a write without it changes nothing
	assign wr_go = PSEL && PENABLE && PREADY && req.wr && req.strb[0]
		&& reg_ok(req.addr, 1'b1);

	// ****************************************
	// Channel engines
	// ****************************************
	for (genvar i = 0; i < mpt_pkg::NCH; i++)
	begin : g_ch
		localparam int P = i / 2; // Pair number

		if (i % 2 == 1)
		begin : g_odd
			// Joined pair: even byte low, odd byte high
			assign cfg[i] = cat_r[P]
				? '{center: cen_r[i], pcm: pcm_r[i],
					per: {per_r[i], per_r[i-1]}, duty: {duty_r[i], duty_r[i-1]}}
				: '{center: cen_r[i], pcm: pcm_r[i],
					per: {8'h00, per_r[i]}, duty: {8'h00, duty_r[i]}};
			assign mute[i] = 1'b0;
			// Counter bytes for software are picked in the answer stage
		end
		else
		begin : g_even
			assign cfg[i] = '{center: cen_r[i], pcm: pcm_r[i],
				per: {8'h00, per_r[i]}, duty: {8'h00, duty_r[i]}};
			assign mute[i] = cat_r[P];
			// The even word of a joined pair reads the odd engine's low byte
		end

		// Even engine of a joined pair stands idle
		assign ch_en[i] = en_r[i] && !mute[i];

		mpt_chan #(
			.W(mpt_pkg::CH_W)
		) u_chan (
			.clk(CLK_SYS),
			.rst(SYS_RST),
			.en(ch_en[i]),
			.cfg(cfg[i]),
			.sh(sh[i]),
			.cnt(cnt[i]),
			.active(act[i])
		);

		mpt_pcm #(
			.W(mpt_pkg::CH_W)
		) u_pcm (
			.clk(CLK_SYS),
			.rst(SYS_RST),
			.en(ch_en[i] && sh[i].pcm),
			.per(sh[i].per),
			.duty(sh[i].duty),
			.pulse(pulse[i])
		);

		assign pick[i] = sh[i].pcm ? pulse[i] : act[i];
	end

	// ****************************************
	// Output stage
	// ****************************************

	// Polarity flips the active level; a muted half rests at its idle level
	always_comb
	begin
		for (int k = 0; k < mpt_pkg::NCH; k++)
			next_pwm[k] = mute[k] ? !pol_r[k] : (pick[k] ~^ pol_r[k]);
	end

	// ****************************************
	// Register file
	// ****************************************

	// Next values of the software settings
	always_comb
	begin
		next_en = en_r;
		next_pol = pol_r;
		next_cen = cen_r;
		next_pcm = pcm_r;
		next_cat = cat_r;
		next_per = per_r;
		next_duty = duty_r;
		if (wr_go)
		begin
			if (bank == mpt_pkg::BANK_CTRL)
			begin
				unique case (req.addr)
					mpt_pkg::OFS_ENABLE: next_en = req.wdata[7:0];
					mpt_pkg::OFS_POLARITY: next_pol = req.wdata[7:0];
					mpt_pkg::OFS_CENTER: next_cen = req.wdata[7:0];
					mpt_pkg::OFS_PCM: next_pcm = req.wdata[7:0];
					mpt_pkg::OFS_CONCAT: next_cat = req.wdata[3:0];
					default: next_en = en_r; // Unreachable after reg_ok
				endcase
			end
			else if (bank == mpt_pkg::OFS_PERIOD[mpt_pkg::BANK_LSB+:3])
				next_per[idx] = req.wdata[7:0];
			else
				next_duty[idx] = req.wdata[7:0];
		end
	end

	// Software settings
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			en_r <= mpt_pkg::RST_BYTE;
			pol_r <= mpt_pkg::RST_POLARITY;
			cen_r <= mpt_pkg::RST_BYTE;
			pcm_r <= mpt_pkg::RST_BYTE;
			cat_r <= mpt_pkg::RST_BYTE[3:0];
			for (int k = 0; k < mpt_pkg::NCH; k++)
			begin
				per_r[k] <= mpt_pkg::RST_PERIOD;
				duty_r[k] <= mpt_pkg::RST_BYTE;
			end
		end
		else
		begin
			en_r <= next_en;
			pol_r <= next_pol;
			cen_r <= next_cen;
			pcm_r <= next_pcm;
			cat_r <= next_cat;
			per_r <= next_per;
			duty_r <= next_duty;
		end
	end

	// ****************************************
	// APB answer
	// ****************************************

	// Counter byte of the addressed channel; a joined pair shows low then high
	always_comb
	begin
		logic [2:0] pr;
		pr = {1'b0, idx[2:1]};
		if (cat_r[pr[1:0]])
			cnt_view = idx[0] ? cnt[idx][15:8] : cnt[{idx[2:1], 1'b1}][7:0];
		else
			cnt_view = cnt[idx][7:0];
	end

	// Answer is prepared in the setup cycle so it leaves flops; zero wait states
	always_comb
	begin
		next_pready = PSEL && !PENABLE;
		next_pslverr = 1'b0;
		next_prdata = PRDATA;
		if (PSEL && !PENABLE)
		begin
			next_pslverr = !reg_ok(req.addr, req.wr);
			next_prdata = '0;
			if (!req.wr && reg_ok(req.addr, 1'b0))
			begin
				if (bank == mpt_pkg::BANK_CTRL)
				begin
					unique case (req.addr)
						mpt_pkg::OFS_ENABLE: next_prdata[7:0] = en_r;
						mpt_pkg::OFS_POLARITY: next_prdata[7:0] = pol_r;
						mpt_pkg::OFS_CENTER: next_prdata[7:0] = cen_r;
						mpt_pkg::OFS_PCM: next_prdata[7:0] = pcm_r;
						mpt_pkg::OFS_CONCAT: next_prdata[3:0] = cat_r;
						default: next_prdata[7:0] = PWM_OUT; // Status word
					endcase
				end
				else if (bank == mpt_pkg::OFS_PERIOD[mpt_pkg::BANK_LSB+:3])
					next_prdata[7:0] = per_r[idx];
				else if (bank == mpt_pkg::OFS_DUTY[mpt_pkg::BANK_LSB+:3])
					next_prdata[7:0] = duty_r[idx];
				else
					next_prdata[7:0] = cnt_view;
			end
		end
	end

	// Bus answer and pins
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			PRDATA <= '0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PWM_OUT <= '0;
		end
		else
		begin
			PRDATA <= next_prdata;
			PREADY <= next_pready;
			PSLVERR <= next_pslverr;
			PWM_OUT <= next_pwm;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_APB_READY: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(PSEL && !PENABLE) |=> PREADY) else $error("no ready after setup");
	AST_JOIN_SETTING: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(cat_r[0] && !en_r[1]) |=> sh[1].per == $past({per_r[1], per_r[0]}))
		else $error("pair not joined");
	AST_JOIN_MUTE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		cat_r[0] |=> PWM_OUT[0] == !$past(pol_r[0])) else $error("muted half moved");
	AST_POLARITY: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(!mute[1] && !pol_r[1] && pick[1]) |=> !PWM_OUT[1]) else $error("polarity wrong");

endmodule
`default_nettype wire

// ==== testbench/multichannel_pwm_timer_tb.sv ====
// Self-checking testbench of the eight-channel PWM timer, driven over APB
`timescale 1ns/1ns
`default_nettype none

module multichannel_pwm_timer_tb;

	// ****************************************
	// Signals and bookkeeping
	// ****************************************
	typedef struct packed {
		logic rd; // Read data is compared
		logic [31:0] data; // Expected read data
		logic err; // Expected error flag
	} mpt_note_t;

	logic CLK_SYS = 1'b0; // 10 MHz clock
	logic SYS_RST = 1'b1; // Reset, active high
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [3:0] PSTRB = 4'hf;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic [7:0] PWM_OUT;
	mpt_note_t notes[$]; // Expected bus answers, oldest first
	mpt_note_t nt;
	int num_errors = 0;
	int n_checks = 0;
	int hits [8]; // High cycles per pin in a window
	int per [8] = '{2, 3, 4, 6, 8, 12, 24, 24}; // All divide 24, so one window fits all
	int duty [8];
	int i;
	int run;
	int seen;
	logic prev;

	mpt_top u_dut (
		.CLK_SYS(CLK_SYS),
		.SYS_RST(SYS_RST),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.PSTRB(PSTRB),
		.PRDATA(PRDATA),
		.PREADY(PREADY),
		.PSLVERR(PSLVERR),
		.PWM_OUT(PWM_OUT)
	);

	// ****************************************
	// Clock and helpers
	// ****************************************
	initial
	begin
		forever #50 CLK_SYS = ~CLK_SYS;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One APB transfer; request held until PREADY is seen high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s, input logic [31:0] exp, input logic err);
		int n;
		notes.push_back('{rd: !w && !err, data: exp, err: err});
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		PSTRB <= s;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		n = 0;
		do
		begin
			@(posedge CLK_SYS);
			n++;
		end
		while (PREADY !== 1'b1 && n < 20);
		if (PREADY !== 1'b1)
		begin
			num_errors++;
			$display("BAD %0t bus answer never came", $time);
			results();
		end
	endtask

	// Release the bus; a setup started in the same step still wins
	task automatic idle();
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 4'hf, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0, 4'hf, exp, 1'b0);
	endtask

	// Counts high cycles of every pin over win cycles
	task automatic count_pins(input int win);
		hits = '{default: 0};
		repeat (win)
		begin
			@(posedge CLK_SYS);
			for (int k = 0; k < 8; k++)
				hits[k] += (PWM_OUT[k] === 1'b1);
		end
	endtask

	// High cycles expected in a window that holds whole periods
	function automatic int exp_hits(input int p, input int d, input bit ctr, input bit pol,
		input int win);
		int on;
		int len;
		len = ctr ? 2 * p : p;
		if (d == 0)
			on = 0; // Fully off
		else if (d >= p)
			on = len; // Fully on
		else
			on = ctr ? 2 * d - 1 : d; // Counter visits 0 and p once, the rest twice
		on = (win / len) * on;
		return pol ? on : win - on;
	endfunction

	// ****************************************
	// Answer monitor: pops the oldest note at each completed transfer
	// ****************************************
	always @(posedge CLK_SYS)
	begin
		if (!SYS_RST && PSEL && PENABLE && PREADY === 1'b1)
		begin
			if (notes.size() == 0)
				check(32'h1, 32'h0, "unexpected answer");
			else
			begin
				nt = notes.pop_front();
				check({31'h0, PSLVERR}, {31'h0, nt.err}, "error flag");
				if (nt.rd)
					check(PRDATA, nt.data, "read data");
			end
		end
	end

	// Whole-run limit
	initial
	begin
		repeat (20000) @(posedge CLK_SYS);
		num_errors++;
		$display("BAD %0t run limit reached", $time);
		results();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		void'($urandom(79387));
		repeat (5) @(posedge CLK_SYS);
		SYS_RST <= 1'b0;
		check({24'h0, PWM_OUT}, 32'h0, "idle pins");
		// Reset values, back to back transfers
		rd(mpt_pkg::OFS_ENABLE, 32'h0);
		rd(mpt_pkg::OFS_POLARITY, 32'hff);
		rd(mpt_pkg::OFS_CENTER, 32'h0);
		rd(mpt_pkg::OFS_PCM, 32'h0);
		rd(mpt_pkg::OFS_CONCAT, 32'h0);
		for (i = 0; i < 8; i++)
		begin
			rd(mpt_pkg::OFS_PERIOD + 8'(4 * i), 32'hff);
			rd(mpt_pkg::OFS_DUTY + 8'(4 * i), 32'h0);
		end
		// Refused accesses and a write with its low lane off
		apb(8'h18, 1'b0, 32'h0, 4'hf, 32'h0, 1'b1);
		apb(mpt_pkg::OFS_OUTSTAT, 1'b1, 32'h1, 4'hf, 32'h0, 1'b1);
		apb(8'h01, 1'b0, 32'h0, 4'hf, 32'h0, 1'b1);
		apb(mpt_pkg::OFS_ENABLE, 1'b1, 32'hff, 4'he, 32'h0, 1'b0);
		rd(mpt_pkg::OFS_ENABLE, 32'h0);
		idle();
		$display("test registers done");
		// Eight independent left-aligned channels, both duty extremes included
		for (i = 0; i < 8; i++)
		begin
			duty[i] = (i == 0) ? 0 : (i == 7) ? 255 : $urandom_range(1, per[i]);
			wr(mpt_pkg::OFS_PERIOD + 8'(4 * i), 32'(per[i]));
			wr(mpt_pkg::OFS_DUTY + 8'(4 * i), 32'(duty[i]));
			rd(mpt_pkg::OFS_PERIOD + 8'(4 * i), 32'(per[i]));
		end
		wr(mpt_pkg::OFS_ENABLE, 32'hff);
		idle();
		repeat (10) @(posedge CLK_SYS);
		count_pins(96);
		for (i = 0; i < 8; i++)
			check(32'(hits[i]), 32'(exp_hits(per[i], duty[i], 0, 1, 96)), "left");
		$display("test left aligned done");
		// Low-active polarity on the low half
		wr(mpt_pkg::OFS_POLARITY, 32'hf0);
		idle();
		repeat (4) @(posedge CLK_SYS);
		count_pins(96);
		for (i = 0; i < 8; i++)
			check(32'(hits[i]), 32'(exp_hits(per[i], duty[i], 0, i > 3, 96)), "pol");
		$display("test polarity done");
		// Center alignment, taken on at the next boundary
		wr(mpt_pkg::OFS_POLARITY, 32'hff);
		wr(mpt_pkg::OFS_CENTER, 32'hff);
		idle();
		repeat (60) @(posedge CLK_SYS);
		count_pins(96);
		for (i = 0; i < 8; i++)
			check(32'(hits[i]), 32'(exp_hits(per[i], duty[i], 1, 1, 96)), "center");
		$display("test center aligned done");
		// Pulse density mode keeps the same active share per period
		wr(mpt_pkg::OFS_CENTER, 32'h0);
		wr(mpt_pkg::OFS_PCM, 32'hff);
		idle();
		repeat (60) @(posedge CLK_SYS);
		count_pins(96);
		for (i = 0; i < 8; i++)
			check(32'(hits[i]), 32'(exp_hits(per[i], duty[i], 0, 1, 96)), "pcm");
		$display("test pcm done");
		// Disabled pins rest at the inverse of their polarity
		wr(mpt_pkg::OFS_ENABLE, 32'h0);
		wr(mpt_pkg::OFS_PCM, 32'h0);
		wr(mpt_pkg::OFS_POLARITY, 32'h0);
		idle();
		repeat (4) @(posedge CLK_SYS);
		check({24'h0, PWM_OUT}, 32'hff, "disabled pins");
		rd(mpt_pkg::OFS_OUTSTAT, 32'hff);
		rd(mpt_pkg::OFS_COUNT + 8'h1c, 32'h0);
		// Channels 1:0 joined, period 261, duty 131
		wr(mpt_pkg::OFS_POLARITY, 32'hff);
		wr(mpt_pkg::OFS_CONCAT, 32'h1);
		wr(mpt_pkg::OFS_PERIOD, 32'h05);
		wr(mpt_pkg::OFS_PERIOD + 8'h04, 32'h01);
		wr(mpt_pkg::OFS_DUTY, 32'h83);
		wr(mpt_pkg::OFS_DUTY + 8'h04, 32'h00);
		wr(mpt_pkg::OFS_ENABLE, 32'h03);
		idle();
		repeat (10) @(posedge CLK_SYS);
		count_pins(522);
		check(32'(hits[1]), 32'd262, "joined pin");
		check(32'(hits[0]), 32'd0, "joined even pin");
		$display("test joined pair done");
		// Duty change in mid-run must not cut a pulse
		wr(mpt_pkg::OFS_ENABLE, 32'h0);
		wr(mpt_pkg::OFS_CONCAT, 32'h0);
		wr(mpt_pkg::OFS_PERIOD, 32'd10);
		wr(mpt_pkg::OFS_DUTY, 32'd5);
		wr(mpt_pkg::OFS_ENABLE, 32'h01);
		idle();
		repeat (20) @(posedge CLK_SYS);
		fork
			begin
				run = 0;
				seen = 0;
				prev = PWM_OUT[0];
				repeat (80)
				begin
					@(posedge CLK_SYS);
					if (PWM_OUT[0] === prev)
						run++;
					else
					begin
						// First edge only ends the partial run seen at the start
						if (seen && prev)
							check(32'(run == 5 || run == 8), 32'h1, "high run");
						else if (seen)
							check(32'(run == 5 || run == 2), 32'h1, "low run");
						seen = 1;
						run = 1;
						prev = PWM_OUT[0];
					end
				end
			end
			begin
				repeat ($urandom_range(2, 11)) @(posedge CLK_SYS);
				wr(mpt_pkg::OFS_DUTY, 32'd8);
				idle();
			end
		join
		count_pins(30);
		check(32'(hits[0]), 32'd24, "new duty");
		$display("test boundary reload done");
		results();
	end

endmodule
`default_nettype wire
